//--- src/cstd_pkg.sv
/*
  Constants shared by the clock select, timer decode and interrupt routing glue.
  Assumes a single 100 MHz core clock and straps that are held static while
  the system runs.
*/
package cstd_pkg;
  // Core clock and on-board oscillator figures.
  localparam int CORE_CLK_MHZ = 100;
  localparam int OSC_FREQ_KHZ = 12000;
  localparam int PROC_MAX_KHZ = 2000;

  // Speed ratio strap encodings and the matching divide lengths.
  localparam logic [1:0] RATIO_DIV12 = 2'h0;
  localparam logic [1:0] RATIO_DIV8 = 2'h1;
  localparam logic [1:0] RATIO_DIV6 = 2'h2;
  localparam logic [1:0] RATIO_BAD = 2'h3;
  localparam logic [3:0] DIV_LEN_12 = 4'hC;
  localparam logic [3:0] DIV_LEN_8 = 4'h8;
  localparam logic [3:0] DIV_LEN_6 = 4'h6;

  // Clock source strap values.
  localparam logic SRC_INTERNAL = 1'h0;
  localparam logic SRC_EXTERNAL = 1'h1;

  // Timer page strap: fitted position reads as zero, so default page is EF.
  localparam logic [7:0] TIMER_PAGE_DEFAULT = 8'hEF;
  localparam int TIMER_REG_LSB = 0;
  localparam int TIMER_REG_BITS = 3;
  localparam int TIMER_COUNT = 3;
  localparam int TIMER_WIDTH = 16;

  // Interrupt routing.
  localparam int IRQ_COUNT = 8;
  localparam logic [15:0] IRQ_VECTOR_ADDR = 16'hFFF8;
  localparam int VEC_FIELD_LSB = 1;
  localparam int VEC_FIELD_BITS = 4;

  // Reset values.
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [3:0] PHASE_CNT_RESET = 4'h0;
endpackage

//--- src/cstd_glue.sv
/*
  Clock source select and divider, and, at the 1 MHz internal oscillator setting
  only, programmable timer page decode with three simple timers and interrupt
  vector steering for an 8-bit processor board.
  Assumes the processor address and valid memory address strobe are on
  core_clk; oscillator, external clock, timer and interrupt pins are async.

*/
`timescale 1ns/10ps
`default_nettype none
module cstd_glue
  import cstd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Configuration straps, held by the system reset
  input wire logic config_hold,
  input wire logic [1:0] speed_ratio_strap,
  input wire logic clock_source_strap,
  input wire logic [7:0] timer_page_strap,
  input wire logic interrupt_unit_socket,
  // Clock sources
  input wire logic internal_osc_clk,
  input wire logic external_clock_input,
  // Processor clock phases and configuration error flag
  output logic phase_one,
  output logic phase_two,
  output logic config_error,
  // Processor address path
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_vma,
  output logic [15:0] mem_addr,
  output logic timer_select_n,
  // Interrupt expansion header, active low
  input wire logic [7:0] interrupt_expansion_header_n,
  output logic cpu_irq_n,
  // Timer pins and settings
  input wire logic timer_one_count_in,
  input wire logic timer_two_count_in,
  input wire logic timer_three_count_in,
  input wire logic timer_one_gate,
  input wire logic timer_two_gate,
  input wire logic timer_three_gate,
  input wire logic [2:0] timer_single_shot,
  input wire logic [15:0] timer_one_reload,
  input wire logic [15:0] timer_two_reload,
  input wire logic [15:0] timer_three_reload,
  output logic [2:0] timer_out
);
  import cstd_pkg::*;

  function automatic logic [3:0] div_len(input logic [1:0] ratio);
    case (ratio)
      RATIO_DIV12: div_len = DIV_LEN_12;
      RATIO_DIV8: div_len = DIV_LEN_8;
      RATIO_DIV6: div_len = DIV_LEN_6;
      default: div_len = DIV_LEN_12;
    endcase
  endfunction

  function automatic logic [2:0] prio_enc(input logic [7:0] req);
    prio_enc = 3'h0;
    for (int i = 0; i < IRQ_COUNT; i++) begin
      if (req[i]) begin
        prio_enc = 3'(i);
      end
    end
  endfunction

  // Pin synchronisers; the third stage only feeds edge detection.
  logic [1:0] src_s1_q, src_s2_q, src_s3_q;
  logic hold_s1_q, hold_s2_q;
  logic [7:0] irq_s1_q, irq_s2_q;
  logic [2:0] cin_s1_q, cin_s2_q, cin_s3_q;
  logic [2:0] gate_s1_q, gate_s2_q, gate_s3_q;
  logic [2:0] cin_pin, gate_pin;

  assign cin_pin = {timer_three_count_in, timer_two_count_in, timer_one_count_in};
  assign gate_pin = {timer_three_gate, timer_two_gate, timer_one_gate};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      src_s1_q <= 2'h0;
      src_s2_q <= 2'h0;
      src_s3_q <= 2'h0;
      hold_s1_q <= 1'h1;
      hold_s2_q <= 1'h1;
      irq_s1_q <= 8'hFF;
      irq_s2_q <= 8'hFF;
      cin_s1_q <= 3'h0;
      cin_s2_q <= 3'h0;
      cin_s3_q <= 3'h0;
      gate_s1_q <= 3'h7;
      gate_s2_q <= 3'h7;
      gate_s3_q <= 3'h7;
    end else begin
      src_s1_q <= {external_clock_input, internal_osc_clk};
      src_s2_q <= src_s1_q;
      src_s3_q <= src_s2_q;
      hold_s1_q <= config_hold;
      hold_s2_q <= hold_s1_q;
      irq_s1_q <= interrupt_expansion_header_n;
      irq_s2_q <= irq_s1_q;
      cin_s1_q <= cin_pin;
      cin_s2_q <= cin_s1_q;
      cin_s3_q <= cin_s2_q;
      gate_s1_q <= gate_pin;
      gate_s2_q <= gate_s1_q;
      gate_s3_q <= gate_s2_q;
    end
  end

  // Strap capture while the system is held; straps are ignored afterwards.
  logic [1:0] ratio_q;
  logic src_ext_q, fitted_q;
  logic [7:0] page_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ratio_q <= RATIO_DIV12;
      src_ext_q <= SRC_INTERNAL;
      fitted_q <= 1'h0;
      page_q <= TIMER_PAGE_DEFAULT;
    end else if (hold_s2_q) begin
      ratio_q <= speed_ratio_strap;
      src_ext_q <= clock_source_strap;
      fitted_q <= interrupt_unit_socket;
      page_q <= timer_page_strap;
    end
  end

  // A strap combination the board cannot run is flagged, not silently fixed.
  logic ratio_bad, one_mhz;
  assign ratio_bad = (ratio_q == RATIO_BAD);
  assign one_mhz = (ratio_q == RATIO_DIV12) && (src_ext_q == SRC_INTERNAL);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      config_error <= 1'h0;
    end else begin
      config_error <= ratio_bad || (fitted_q && !one_mhz);
    end
  end

  // Source select and divider.
  logic src_tick;
  logic [3:0] len, phase_cnt_q;
  assign src_tick = src_ext_q ? (src_s2_q[1] & ~src_s3_q[1])
                              : (src_s2_q[0] & ~src_s3_q[0]);
  assign len = div_len(ratio_q);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase_cnt_q <= PHASE_CNT_RESET;
    end else if (hold_s2_q || ratio_bad) begin
      phase_cnt_q <= PHASE_CNT_RESET;
    end else if (src_tick) begin
      phase_cnt_q <= (phase_cnt_q >= len - 4'h1) ? 4'h0 : phase_cnt_q + 4'h1;
    end
  end

  // A dead source tick at each half boundary keeps the phases apart.
  logic [3:0] half;
  assign half = {1'b0, len[3:1]};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase_one <= 1'h0;
      phase_two <= 1'h0;
    end else if (hold_s2_q || ratio_bad) begin
      phase_one <= 1'h0;
      phase_two <= 1'h0;
    end else begin
      phase_one <= (phase_cnt_q < half - 4'h1);
      phase_two <= (phase_cnt_q >= half) && (phase_cnt_q < len - 4'h1);
    end
  end

  // Timer page decode: A7..A3 do not take part, so the page aliases.
  logic page_hit;
  assign page_hit = (cpu_addr[15:8] == page_q);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timer_select_n <= 1'h1;
    end else begin
      timer_select_n <= !(cpu_vma && page_hit && one_mhz);
    end
  end

  // Interrupt routing and vector steering.
  logic [7:0] irq_act;
  logic unit_live, vec_fetch;
  assign irq_act = ~irq_s2_q;
  assign unit_live = fitted_q && one_mhz;
  assign vec_fetch = cpu_vma && (cpu_addr[15:1] == IRQ_VECTOR_ADDR[15:1]);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mem_addr <= ADDR_RESET;
      cpu_irq_n <= 1'h1;
    end else begin
      cpu_irq_n <= !(|irq_act);
      if (unit_live && vec_fetch && (|irq_act)) begin
        mem_addr <= {cpu_addr[15:5], 1'b0, prio_enc(irq_act), cpu_addr[0]};
      end else begin
        mem_addr <= cpu_addr;
      end
    end
  end

  // Three timers; gate is active low, count rises decrement.
  logic [15:0] reload [TIMER_COUNT];
  logic [15:0] tcount_q [TIMER_COUNT];
  logic [2:0] trun_q, cin_rise, gate_fall;
  assign reload[0] = timer_one_reload;
  assign reload[1] = timer_two_reload;
  assign reload[2] = timer_three_reload;
  assign cin_rise = cin_s2_q & ~cin_s3_q;
  assign gate_fall = gate_s3_q & ~gate_s2_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < TIMER_COUNT; i++) begin
        tcount_q[i] <= 16'h0000;
      end
      trun_q <= 3'h0;
      timer_out <= 3'h0;
    end else begin
      for (int i = 0; i < TIMER_COUNT; i++) begin
        if (!one_mhz) begin
          tcount_q[i] <= reload[i];
          trun_q[i] <= 1'h0;
          timer_out[i] <= 1'h0;
        end else if (timer_single_shot[i]) begin
          if (gate_fall[i]) begin
            tcount_q[i] <= reload[i];
            trun_q[i] <= 1'h1;
            timer_out[i] <= 1'h1;
          end else if (trun_q[i] && cin_rise[i]) begin
            if (tcount_q[i] == 16'h0000) begin
              trun_q[i] <= 1'h0;
              timer_out[i] <= 1'h0;
            end else begin
              tcount_q[i] <= tcount_q[i] - 16'h0001;
            end
          end
        end else begin
          trun_q[i] <= !gate_s2_q[i];
          if (!gate_s2_q[i] && cin_rise[i]) begin
            if (tcount_q[i] == 16'h0000) begin
              tcount_q[i] <= reload[i];
              timer_out[i] <= !timer_out[i];
            end else begin
              tcount_q[i] <= tcount_q[i] - 16'h0001;
            end
          end
        end
      end
    end
  end

  a_phase_no_overlap: assert property (@(posedge core_clk) disable iff (!rstn)
    !(phase_one && phase_two))
    else $error("processor clock phases overlap");

  a_phase_cnt_range: assert property (@(posedge core_clk) disable iff (!rstn)
    phase_cnt_q < len)
    else $error("divider count ran past its ratio");

  a_src_select: assert property (@(posedge core_clk) disable iff (!rstn)
    (!hold_s2_q && !ratio_bad && src_tick && phase_cnt_q < len - 4'h1)
      |=> phase_cnt_q == $past(phase_cnt_q) + 4'h1)
    else $error("divider missed a selected source edge");

  a_straps_frozen: assert property (@(posedge core_clk) disable iff (!rstn)
    !hold_s2_q |=> $stable(ratio_q) && $stable(src_ext_q))
    else $error("straps changed outside reset hold");

  a_timer_select: assert property (@(posedge core_clk) disable iff (!rstn)
    (cpu_vma && cpu_addr[15:8] == page_q && one_mhz) |=> !timer_select_n)
    else $error("timer page access not selected");

  a_select_gated: assert property (@(posedge core_clk) disable iff (!rstn)
    (!one_mhz || !cpu_vma) |=> timer_select_n)
    else $error("timer selected when not allowed");

  a_bypass_path: assert property (@(posedge core_clk) disable iff (!rstn)
    !unit_live |=> mem_addr == $past(cpu_addr))
    else $error("bypass altered the address");

  a_vector_steer: assert property (@(posedge core_clk) disable iff (!rstn)
    (unit_live && vec_fetch && irq_act[7])
      |=> mem_addr[4:1] == 4'h7 && mem_addr[15:5] == $past(cpu_addr[15:5]))
    else $error("top interrupt not steered to its vector");

  a_irq_route: assert property (@(posedge core_clk) disable iff (!rstn)
    (|irq_act) |=> !cpu_irq_n)
    else $error("header interrupt not passed on");

  a_count_dec: assert property (@(posedge core_clk) disable iff (!rstn)
    (one_mhz && !timer_single_shot[0] && !gate_s2_q[0] && cin_rise[0]
      && tcount_q[0] != 16'h0000) |=> tcount_q[0] == $past(tcount_q[0]) - 16'h0001)
    else $error("timer one did not decrement");

  a_shot_start: assert property (@(posedge core_clk) disable iff (!rstn)
    (one_mhz && timer_single_shot[1] && gate_fall[1]) |=> timer_out[1] && trun_q[1])
    else $error("single-shot trigger did not raise the output");
endmodule
`default_nettype wire

//--- tb/cstd_far_model.sv
/*
  Far-side model: both clock sources, timer count and gate pins, and the
  interrupt header lines. Pins are asynchronous to the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cstd_far_model (
  // Clock sources
  output var logic internal_osc_clk,
  output var logic external_clock_input,
  // Timer pins
  output var logic timer_one_count_in,
  output var logic timer_two_count_in,
  output var logic timer_three_count_in,
  output var logic timer_one_gate,
  output var logic timer_two_gate,
  output var logic timer_three_gate,
  // Interrupt header, active low with pull-ups
  output var logic [7:0] interrupt_expansion_header_n
);
  initial begin
    internal_osc_clk = 1'h0;
    forever #41.67 internal_osc_clk = ~internal_osc_clk;
  end
  // At 8 MHz even the shortest ratio keeps the processor clock below its limit.
  initial begin
    external_clock_input = 1'h0;
    forever #62.5 external_clock_input = ~external_clock_input;
  end
  initial begin
    {timer_three_count_in, timer_two_count_in, timer_one_count_in} = 3'h0;
    {timer_three_gate, timer_two_gate, timer_one_gate} = 3'h7;
    interrupt_expansion_header_n = 8'hFF;
  end
  task pulses(input logic [2:0] m, input int n);
    repeat (n) begin
      #50 {timer_three_count_in, timer_two_count_in, timer_one_count_in} = m;
      #50 {timer_three_count_in, timer_two_count_in, timer_one_count_in} = 3'h0;
    end
  endtask
  task set_gate(input logic [2:0] g);
    {timer_three_gate, timer_two_gate, timer_one_gate} = g;
  endtask
  task set_irq(input logic [7:0] v);
    interrupt_expansion_header_n = v;
  endtask
endmodule
`default_nettype wire

//--- tb/clock_select_timer_decode_bench.sv
/*
  Self-checking bench for the glue block. Drives the processor side itself
  and the pins through the far-side model.
*/
`timescale 1ns/10ps
`default_nettype none
module clock_select_timer_decode_bench;
  import cstd_pkg::*;
  logic core_clk, rstn, config_hold, clock_source_strap, interrupt_unit_socket, cpu_vma;
  logic [1:0] speed_ratio_strap;
  logic [7:0] timer_page_strap, interrupt_expansion_header_n;
  logic [15:0] cpu_addr, mem_addr, timer_one_reload, timer_two_reload, timer_three_reload;
  logic [2:0] timer_single_shot, timer_out;
  logic internal_osc_clk, external_clock_input, phase_one, phase_two, config_error;
  logic timer_select_n, cpu_irq_n, timer_one_count_in, timer_two_count_in;
  logic timer_three_count_in, timer_one_gate, timer_two_gate, timer_three_gate;
  int error_cnt, n_compared, i;

  cstd_glue u_dut (.core_clk, .rstn, .config_hold, .speed_ratio_strap,
    .clock_source_strap, .timer_page_strap, .interrupt_unit_socket, .internal_osc_clk,
    .external_clock_input, .phase_one, .phase_two, .config_error, .cpu_addr, .cpu_vma,
    .mem_addr, .timer_select_n, .interrupt_expansion_header_n, .cpu_irq_n,
    .timer_one_count_in, .timer_two_count_in, .timer_three_count_in, .timer_one_gate,
    .timer_two_gate, .timer_three_gate, .timer_single_shot, .timer_one_reload,
    .timer_two_reload, .timer_three_reload, .timer_out);
  cstd_far_model u_far (.internal_osc_clk, .external_clock_input, .timer_one_count_in,
    .timer_two_count_in, .timer_three_count_in, .timer_one_gate, .timer_two_gate,
    .timer_three_gate, .interrupt_expansion_header_n);

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  task give_verdict;
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Straps move while the hold is up, and t_speed moves one after cfg to show it is ignored; the bench then waits out the syncs.
  task cfg(input logic [1:0] r, input logic s, input logic [7:0] p, input logic u);
    @(posedge core_clk);
    #1 config_hold = 1'h1;
    speed_ratio_strap = r;
    clock_source_strap = s;
    timer_page_strap = p;
    interrupt_unit_socket = u;
    repeat (5) @(posedge core_clk);
    #1 config_hold = 1'h0;
    repeat (6) @(posedge core_clk);
  endtask
  task bus(input logic [15:0] a, input logic v);
    @(posedge core_clk);
    #1 cpu_addr = a;
    cpu_vma = v;
    @(posedge core_clk);
    #1;
  endtask
  task sel(input logic [15:0] a, input logic v, input logic e);
    bus(a, v);
    chk("timer_select_n", {15'h0, e}, {15'h0, timer_select_n});
    chk("mem_addr", a, mem_addr);
  endtask
  // Span of three phase one periods, with a little slack for pin sync jitter.
  task per(input int exp);
    int n, r, c, r2;
    logic p, ov, q;
    r = 0;
    c = 0;
    r2 = 0;
    ov = 1'h0;
    p = phase_one;
    q = phase_two;
    for (n = 0; n < 3000 && r < 4; n++) begin
      @(posedge core_clk);
      #1;
      if (phase_one === 1'h1 && phase_two === 1'h1) ov = 1'h1;
      if (phase_one === 1'h1 && p === 1'h0) r++;
      if (r > 0) c++;
      if (r > 0 && phase_two === 1'h1 && q === 1'h0) r2++;
      p = phase_one;
      q = phase_two;
    end
    if (r < 4 || c - 1 > exp + 3 || c - 1 < exp - 3) chk("phase_span", 16'(exp), 16'(c - 1));
    else chk("phase_span", 16'(exp), 16'(exp));
    chk("phase_overlap", 16'h0, {15'h0, ov});
    chk("phase_two_rises", 16'h3, 16'(r2));
  endtask
  // A wait that runs out counts as a mismatch, so a hang can never pass.
  task wirq(input logic w);
    int k;
    for (k = 0; k < 50 && cpu_irq_n !== w; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk("cpu_irq_n", {15'h0, w}, {15'h0, cpu_irq_n});
    if (k == 50) begin
      error_cnt++;
      give_verdict;
    end
  endtask

  task t_decode;
    cfg(RATIO_DIV12, SRC_INTERNAL, TIMER_PAGE_DEFAULT, 1'h0);
    sel(16'hEF00, 1'h1, 1'h0);
    sel(16'hEF07, 1'h1, 1'h0);
    sel(16'hEFF8, 1'h1, 1'h0);
    sel(16'hEE07, 1'h1, 1'h1);
    sel(16'hEF03, 1'h0, 1'h1);
    cfg(RATIO_DIV12, SRC_INTERNAL, 8'h9F, 1'h0);
    sel(16'h9F05, 1'h1, 1'h0);
    sel(16'hEF05, 1'h1, 1'h1);
    cfg(RATIO_DIV8, SRC_INTERNAL, TIMER_PAGE_DEFAULT, 1'h0);
    sel(16'hEF05, 1'h1, 1'h1);
    cfg(RATIO_DIV12, SRC_EXTERNAL, TIMER_PAGE_DEFAULT, 1'h0);
    sel(16'hEF05, 1'h1, 1'h1);
  endtask
  task t_speed;
    cfg(RATIO_DIV12, SRC_INTERNAL, TIMER_PAGE_DEFAULT, 1'h0);
    #1 speed_ratio_strap = RATIO_DIV6;
    per(300);
    cfg(RATIO_DIV8, SRC_INTERNAL, TIMER_PAGE_DEFAULT, 1'h0);
    per(200);
    cfg(RATIO_DIV6, SRC_INTERNAL, TIMER_PAGE_DEFAULT, 1'h0);
    per(150);
    cfg(RATIO_DIV8, SRC_EXTERNAL, TIMER_PAGE_DEFAULT, 1'h0);
    per(300);
    cfg(RATIO_BAD, SRC_INTERNAL, TIMER_PAGE_DEFAULT, 1'h0);
    repeat (100) @(posedge core_clk);
    #1 chk("config_error", 16'h1, {15'h0, config_error});
    chk("phases", 16'h0, {14'h0, phase_one, phase_two});
    cfg(RATIO_DIV8, SRC_INTERNAL, TIMER_PAGE_DEFAULT, 1'h1);
    #1 chk("config_error", 16'h1, {15'h0, config_error});
  endtask
  task t_irq;
    cfg(RATIO_DIV12, SRC_INTERNAL, TIMER_PAGE_DEFAULT, 1'h1);
    #1 chk("config_error", 16'h0, {15'h0, config_error});
    for (i = 0; i < IRQ_COUNT; i++) begin
      u_far.set_irq(~(8'h01 << i));
      // The previous line may still be active; let the new pattern clear the syncs.
      repeat (3) @(posedge core_clk);
      wirq(1'h0);
      bus(IRQ_VECTOR_ADDR, 1'h1);
      chk("mem_addr", 16'hFFE0 | 16'(i * 2), mem_addr);
    end
    u_far.set_irq(8'hD7);
    repeat (5) @(posedge core_clk);
    bus(IRQ_VECTOR_ADDR, 1'h1);
    chk("mem_addr", 16'hFFEA, mem_addr);
    u_far.set_irq(8'hFF);
    wirq(1'h1);
    sel(IRQ_VECTOR_ADDR, 1'h1, 1'h1);
    cfg(RATIO_DIV12, SRC_INTERNAL, TIMER_PAGE_DEFAULT, 1'h0);
    u_far.set_irq(8'hF7);
    wirq(1'h0);
    sel(IRQ_VECTOR_ADDR, 1'h1, 1'h1);
    u_far.set_irq(8'hFF);
  endtask
  task t_timer;
    cfg(RATIO_DIV12, SRC_INTERNAL, TIMER_PAGE_DEFAULT, 1'h0);
    u_far.pulses(3'h5, 3);
    repeat (5) @(posedge core_clk);
    chk("timer_out", 16'h0, {13'h0, timer_out});
    u_far.set_gate(3'h2);
    repeat (5) @(posedge core_clk);
    u_far.pulses(3'h5, 3);
    repeat (5) @(posedge core_clk);
    chk("timer_out", 16'h5, {13'h0, timer_out});
    u_far.set_gate(3'h0);
    repeat (5) @(posedge core_clk);
    chk("timer_out", 16'h7, {13'h0, timer_out});
    u_far.pulses(3'h2, 2);
    repeat (5) @(posedge core_clk);
    chk("timer_out", 16'h7, {13'h0, timer_out});
    u_far.pulses(3'h2, 1);
    repeat (5) @(posedge core_clk);
    chk("timer_out", 16'h5, {13'h0, timer_out});
    // All continuous now; a zero reload on timer one makes it toggle every rise once its running count has reached zero.
    @(posedge core_clk);
    #1 timer_single_shot = 3'h0;
    timer_one_reload = 16'h0000;
    u_far.pulses(3'h3, 3);
    repeat (5) @(posedge core_clk);
    chk("timer_out", 16'h6, {13'h0, timer_out});
    u_far.pulses(3'h1, 1);
    repeat (5) @(posedge core_clk);
    chk("timer_out", 16'h7, {13'h0, timer_out});
  endtask

  initial begin
    error_cnt = 0;
    n_compared = 0;
    rstn = 1'h0;
    config_hold = 1'h0;
    speed_ratio_strap = RATIO_DIV12;
    clock_source_strap = SRC_INTERNAL;
    timer_page_strap = TIMER_PAGE_DEFAULT;
    interrupt_unit_socket = 1'h0;
    cpu_addr = ADDR_RESET;
    cpu_vma = 1'h0;
    timer_single_shot = 3'h2;
    timer_one_reload = 16'h0002;
    timer_two_reload = 16'h0002;
    timer_three_reload = 16'h0002;
    repeat (10) @(posedge core_clk);
    chk("reset_outs", 16'h0003, {11'h0, phase_one, phase_two, config_error, timer_select_n,
      cpu_irq_n});
    chk("reset_timer", 16'h0000, {13'h0, timer_out});
    chk("reset_addr", ADDR_RESET, mem_addr);
    #1 rstn = 1'h1;
    t_decode;
    t_speed;
    t_irq;
    t_timer;
    give_verdict;
  end
endmodule
`default_nettype wire
